// ===== hdl/scb_ctl3_bank.v
// control 3 register bank and switch drivers for four type B blocks
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "scb_ctl3_defs.vh"

// Contract
// - reference select: 00 ground, 01 high, 10 low, 11 follows comparator.
// - feedback switch enable zero keeps integrator switch always off.
// - feedback enable one, auto_null_control zero: integrator switch always on.
// - feedback enable and auto_null_control both one: switch on only during phase2.
// - output-to-ground switch off at zero, on during phase1 at one.
// - B switching disabled leaves B branch as continuous-time path.
// - B switching: both ends grounded on phase1, input/summing on phase2.
// - bit 2 picks which neighbouring block feeds the B branch.
// - four register instances, same address in either bank, read/write.
// - auto_null_control comes from bit 5 of the same block's control 2.

module scb_ctl3_bank #(
  parameter NBLK = 4
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_ff,
  // analog state: per-block bits in order 11, 13, 20, 22, and the shared phase1 and phase2
  input wire [NBLK-1:0] auto_null_control,
  input wire [NBLK-1:0] cmp_out,
  input wire phase1,
  input wire phase2,
  // switch enables one bit per block, bias_power two bits per block
  output wire [NBLK-1:0] ref_gnd,
  output wire [NBLK-1:0] ref_high,
  output wire [NBLK-1:0] ref_low,
  output wire [NBLK-1:0] integ_fb_sw,
  output wire [NBLK-1:0] out_gnd_sw,
  output wire [NBLK-1:0] b_cont,
  output wire [NBLK-1:0] b_gnd_sw,
  output wire [NBLK-1:0] b_in_sw,
  output wire [NBLK-1:0] b_input_source_select,
  output wire [2*NBLK-1:0] bias_power
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  reg [7:0] ctl_ff [0:3];
  reg [3:0] hit;
  reg [7:0] nxt_rdata;
  integer i;
  integer j;

  // bank select is not decoded: each register answers in both banks
  always @* begin
    hit[0] = (reg_addr == `SCB_BLK11_CTL3_OFS);
    hit[1] = (reg_addr == `SCB_BLK13_CTL3_OFS);
    hit[2] = (reg_addr == `SCB_BLK20_CTL3_OFS);
    hit[3] = (reg_addr == `SCB_BLK22_CTL3_OFS);
    nxt_rdata = `SCB_UNMAPPED_RDATA;
    for (i = 0; i < 4; i = i + 1) begin
      if (hit[i]) begin
        nxt_rdata = ctl_ff[i];
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (j = 0; j < 4; j = j + 1) begin
        ctl_ff[j] <= `SCB_CTL3_RESET;
      end
      reg_rdata_ff <= 8'h00;
    end else begin
      for (j = 0; j < 4; j = j + 1) begin
        if (reg_wr && hit[j]) begin
          ctl_ff[j] <= reg_wdata;
        end
      end
      // read data stand only in the cycle after each reg_rd cycle, zero otherwise
      reg_rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
    end
  end

  // ----------------------------------------
  // per-block switch drivers
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NBLK; g = g + 1) begin : blk
      scb_sw_gate u_gate (
        .clock(clock),
        .rst_n(rst_n),
        .ctl(ctl_ff[g]),
        .auto_null_control(auto_null_control[g]),
        .cmp_out(cmp_out[g]),
        .phase1(phase1),
        .phase2(phase2),
        .ref_gnd_ff(ref_gnd[g]),
        .ref_high_ff(ref_high[g]),
        .ref_low_ff(ref_low[g]),
        .integ_fb_sw_ff(integ_fb_sw[g]),
        .out_gnd_sw_ff(out_gnd_sw[g]),
        .b_cont_ff(b_cont[g]),
        .b_gnd_sw_ff(b_gnd_sw[g]),
        .b_in_sw_ff(b_in_sw[g]),
        .b_src_sel_ff(b_input_source_select[g]),
        .bias_power_ff(bias_power[2*g+1:2*g])
      );
    end
  endgenerate

endmodule // scb_ctl3_bank

`default_nettype wire

// ===== hdl/scb_ctl3_defs.vh
// constants for the type B switch control register bank
`ifndef SCB_CTL3_DEFS_VH
`define SCB_CTL3_DEFS_VH

// ----------------------------------------
// register offsets, reset value and unmapped read data
// ----------------------------------------
`define SCB_BLK11_CTL3_OFS 8'h87
`define SCB_BLK13_CTL3_OFS 8'h8F
`define SCB_BLK20_CTL3_OFS 8'h93
`define SCB_BLK22_CTL3_OFS 8'h9B
`define SCB_CTL3_RESET 8'h00
`define SCB_UNMAPPED_RDATA 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define SCB_AREF_HI 7
`define SCB_AREF_LO 6
`define SCB_FB_SW_BIT 5
`define SCB_GND_SW_BIT 4
`define SCB_BSW_BIT 3
`define SCB_BSRC_BIT 2
`define SCB_PWR_HI 1
`define SCB_PWR_LO 0

// ----------------------------------------
// reference select codes
// ----------------------------------------
`define SCB_AREF_AGND 2'h0
`define SCB_AREF_HIGH 2'h1
`define SCB_AREF_LOW 2'h2
`define SCB_AREF_CMP 2'h3

`endif

// ===== hdl/scb_sw_gate.v
// phase-gated switch enables for one type B block
`timescale 1ns/10ps
`default_nettype none
`include "scb_ctl3_defs.vh"

module scb_sw_gate (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // control fields and analog state
  input wire [7:0] ctl,
  input wire auto_null_control,
  input wire cmp_out,
  input wire phase1,
  input wire phase2,
  // switch enables
  output reg ref_gnd_ff,
  output reg ref_high_ff,
  output reg ref_low_ff,
  output reg integ_fb_sw_ff,
  output reg out_gnd_sw_ff,
  output reg b_cont_ff,
  output reg b_gnd_sw_ff,
  output reg b_in_sw_ff,
  output reg b_src_sel_ff,
  output reg [1:0] bias_power_ff
);

  wire [1:0] aref;
  reg nxt_ref_gnd;
  reg nxt_ref_high;
  reg nxt_ref_low;
  reg nxt_integ_fb_sw;
  wire b_branch_switching_enable;

  assign aref = ctl[`SCB_AREF_HI:`SCB_AREF_LO];
  assign b_branch_switching_enable = ctl[`SCB_BSW_BIT];

  // ----------------------------------------
  // reference and feedback decode
  // ----------------------------------------
  always @* begin
    nxt_ref_gnd = 1'b0;
    nxt_ref_high = 1'b0;
    nxt_ref_low = 1'b0;
    case (aref)
      `SCB_AREF_AGND: nxt_ref_gnd = 1'b1;
      `SCB_AREF_HIGH: nxt_ref_high = 1'b1;
      `SCB_AREF_LOW: nxt_ref_low = 1'b1;
      default: begin
        nxt_ref_high = cmp_out;
        nxt_ref_low = ~cmp_out;
      end
    endcase
    if (!ctl[`SCB_FB_SW_BIT]) begin
      nxt_integ_fb_sw = 1'b0;
    end else if (!auto_null_control) begin
      nxt_integ_fb_sw = 1'b1;
    end else begin
      nxt_integ_fb_sw = phase2;
    end
  end

  // ----------------------------------------
  // output flops
  // ----------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ref_gnd_ff <= 1'b0;
      ref_high_ff <= 1'b0;
      ref_low_ff <= 1'b0;
      integ_fb_sw_ff <= 1'b0;
      out_gnd_sw_ff <= 1'b0;
      b_cont_ff <= 1'b0;
      b_gnd_sw_ff <= 1'b0;
      b_in_sw_ff <= 1'b0;
      b_src_sel_ff <= 1'b0;
      bias_power_ff <= 2'h0;
    end else begin
      ref_gnd_ff <= nxt_ref_gnd;
      ref_high_ff <= nxt_ref_high;
      ref_low_ff <= nxt_ref_low;
      integ_fb_sw_ff <= nxt_integ_fb_sw;
      out_gnd_sw_ff <= ctl[`SCB_GND_SW_BIT] & phase1;
      b_cont_ff <= ~b_branch_switching_enable;
      b_gnd_sw_ff <= b_branch_switching_enable & phase1;
      b_in_sw_ff <= b_branch_switching_enable & phase2;
      b_src_sel_ff <= ctl[`SCB_BSRC_BIT];
      bias_power_ff <= ctl[`SCB_PWR_HI:`SCB_PWR_LO];
    end
  end

endmodule // scb_sw_gate

`default_nettype wire

// ===== tb/scb_ctl3_bank_tb.sv
// self-checking bench for the type B control 3 bank
`timescale 1ns/10ps
`default_nettype none
`include "scb_ctl3_defs.vh"
module scb_ctl3_bank_tb;
  logic clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, phase1 = 1'b0, phase2 = 1'b0, p1, p2;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_ff, bias_power, m [0:3];
  logic [7:0] adr [0:3] = '{`SCB_BLK11_CTL3_OFS, `SCB_BLK13_CTL3_OFS, `SCB_BLK20_CTL3_OFS, `SCB_BLK22_CTL3_OFS};
  logic [3:0] auto_null_control = 4'h0, cmp_out = 4'h0, an, cp, ref_gnd, ref_high, ref_low, integ_fb_sw;
  logic [3:0] out_gnd_sw, b_cont, b_gnd_sw, b_in_sw, b_input_source_select;
  logic [15:0] sw;
  int mismatches = 0, checked = 0, cyc = 0;
  scb_ctl3_bank scb_ctl3_bank_inst (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .auto_null_control(auto_null_control),
    .cmp_out(cmp_out), .phase1(phase1), .phase2(phase2), .ref_gnd(ref_gnd), .ref_high(ref_high),
    .ref_low(ref_low), .integ_fb_sw(integ_fb_sw), .out_gnd_sw(out_gnd_sw), .b_cont(b_cont), .b_gnd_sw(b_gnd_sw),
    .b_in_sw(b_in_sw), .b_input_source_select(b_input_source_select), .bias_power(bias_power));
  initial forever #25 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      close_out;
    end
  end
  task close_out;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  function logic [15:0] ex(input logic [7:0] r, input logic a, c, h1, h2);
    ex = {5'h00, r[7:6] == 2'h0, r[7:6] == 2'h1 || r[7:6] == 2'h3 && c, r[7:6] == 2'h2 || r[7:6] == 2'h3 && !c,
      r[5] & (!a | h2), r[4] & h1, !r[3], r[3] & h1, r[3] & h2, r[2], r[1:0]};
  endfunction
  task bus(input logic w, r, input logic [7:0] a, d);
    @(posedge clock);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  // read sampled at the following edge, data valid in the cycle after
  task rd(input logic [7:0] a, e);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, a, 8'h00);
    @(negedge clock);
    chk("rdata", reg_rdata_ff, e);
  endtask
  // release reset after two edges, then every output must decode an all-zero register and every register must read zero
  task after_rst;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    @(negedge clock);
    chk("reset", {ref_gnd, b_cont, ref_high, out_gnd_sw}, 16'hFF00);
    chk("reset", {ref_low, integ_fb_sw, b_gnd_sw, b_in_sw}, 16'h0000);
    chk("reset", {4'h0, b_input_source_select, bias_power}, 16'h0000);
    for (int g = 0; g < 4; g++) rd(adr[g], 8'h00);
  endtask
  initial begin
    void'($urandom(32'h58cfc544));
    after_rst;
    for (int k = 0; k < 40; k++) begin
      for (int g = 0; g < 4; g++) begin
        m[g] = k == 0 ? 8'hFF : k == 1 ? 8'h38 : 8'($urandom);
        bus(1'b1, 1'b0, adr[g], m[g]);
        rd(adr[g], m[g]);
      end
      bus(1'b1, 1'b0, 8'h86, 8'h5A);
      rd(8'h86, 8'h00);
      rd(adr[k % 4], m[k % 4]);
      repeat (8) begin
        an = 4'($urandom);
        cp = 4'($urandom);
        p1 = 1'($urandom);
        p2 = !p1 && 1'($urandom);
        @(posedge clock);
        auto_null_control <= an;
        cmp_out <= cp;
        phase1 <= p1;
        phase2 <= p2;
        @(posedge clock);
        @(negedge clock);
        for (int g = 0; g < 4; g++) begin
          sw = {5'h00, ref_gnd[g], ref_high[g], ref_low[g], integ_fb_sw[g], out_gnd_sw[g], b_cont[g],
            b_gnd_sw[g], b_in_sw[g], b_input_source_select[g], bias_power[2*g+:2]};
          chk("switch", sw, ex(m[g], an[g], cp[g], p1, p2));
        end
      end
    end
    // reset in mid-run must clear the written registers
    @(posedge clock);
    rst_n <= 1'b0;
    after_rst;
    close_out;
  end
endmodule // scb_ctl3_bank_tb
bind scb_ctl3_bank scb_ctl3_sva scb_ctl3_sva_inst (.clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .phase1(phase1), .phase2(phase2),
  .auto_null_control(auto_null_control), .ref_gnd(ref_gnd), .ref_high(ref_high), .ref_low(ref_low),
  .integ_fb_sw(integ_fb_sw), .out_gnd_sw(out_gnd_sw), .b_cont(b_cont), .b_gnd_sw(b_gnd_sw), .b_in_sw(b_in_sw));
`default_nettype wire

// ===== tb/scb_ctl3_sva.sv
// port assertions for the type B control 3 bank
`timescale 1ns/10ps
`default_nettype none
`include "scb_ctl3_defs.vh"
module scb_ctl3_sva (
  // clock, reset and register port
  input wire logic clock, rst_n, reg_wr, reg_rd,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata_ff,
  // analog state and switch enables
  input wire logic phase1, phase2,
  input wire logic [3:0] auto_null_control, ref_gnd, ref_high, ref_low,
  input wire logic [3:0] integ_fb_sw, out_gnd_sw, b_cont, b_gnd_sw, b_in_sw
);
  wire logic hit = reg_addr inside {`SCB_BLK11_CTL3_OFS, `SCB_BLK13_CTL3_OFS,
    `SCB_BLK20_CTL3_OFS, `SCB_BLK22_CTL3_OFS};
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  ref_one_hot_a: assert property ($past(rst_n) |-> (ref_gnd ^ ref_high ^ ref_low) == 4'hF && !(ref_high & ref_low))
    else $error("ref select not one-hot");
  fb_gate_a: assert property (!(integ_fb_sw & $past(auto_null_control) & ~{4{$past(phase2)}}))
    else $error("feedback switch on outside phase2");
  gnd_gate_a: assert property (!(out_gnd_sw & ~{4{$past(phase1)}}))
    else $error("ground switch on outside phase1");
  b_mode_a: assert property (!(b_cont & (b_gnd_sw | b_in_sw)) && !(b_gnd_sw & b_in_sw))
    else $error("b branch modes overlap");
  b_phase_a: assert property (!(b_gnd_sw & ~{4{$past(phase1)}} | b_in_sw & ~{4{$past(phase2)}}))
    else $error("b switch out of phase");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_ff == 8'h00)
    else $error("read data outside read slot");
  rd_unmap_a: assert property ($past(reg_rd) && !$past(hit) |-> reg_rdata_ff == 8'h00)
    else $error("unmapped read not zero");
  rd_back_a: assert property ($past(reg_wr, 2) && $past(reg_rd) && $past(hit) && $past(reg_addr) == $past(reg_addr, 2)
    |-> reg_rdata_ff == $past(reg_wdata, 2))
    else $error("read after write mismatch");
endmodule // scb_ctl3_sva
`default_nettype wire
